//--- rtl/fdl_fault_detect_latch.v
`timescale 1ns/1ns
`default_nettype none
`include "fdl_consts.vh"

// Overview of operation
// - confirmed overtemperature switches all output transistors off
// - brief overtemperature glitches are blanked out
// - overtemperature must persist more than 32 oscillator cycles
// - confirmed overcurrent switches all output transistors off
// - overcurrent must persist more than 8 oscillator cycles
// - fault stays latched until supply cycle or standby
// - fault flag pulled low while fault latched
// - fault flag released by supply cycle or standby
// - warning output follows condition, never latches
module fdl_fault_detect_latch (
    input wire core_clk_i,
    input wire rstn_i,
    input wire thermal_shutdown_i,
    input wire overcurrent_shutdown_i,
    input wire thermal_warning_i,
    input wire low_power_standby_i,
    output reg outputs_off_o,
    output reg thermal_fault_o,
    output reg overcurrent_fault_o,
    output reg fault_flag_o,
    output reg fault_flag_oe_o,
    output reg thermal_warning_out_o,
    output reg thermal_warning_out_oe_o
);

    // ------------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------------

    // synchroniser step: new pin sample in, older sample moves on
    function [1:0] fdl_sync_step;
        input [1:0] q;
        input d;
        begin
            fdl_sync_step = {q[0], d};
        end
    endfunction

    // latch next state: a confirmed set beats the standby clear
    function fdl_latch_next;
        input q;
        input set;
        input clr;
        begin
            fdl_latch_next = q;
            if (clr) begin
                fdl_latch_next = `FDL_LATCH_RST;
            end
            if (set) begin
                fdl_latch_next = 1'b1;
            end
        end
    endfunction

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    reg [1:0] therm_sync_q;
    reg [1:0] overcur_sync_q;
    reg [1:0] warn_sync_q;
    reg [1:0] low_power_standby_sync_q;

    // only the second flop of each pair feeds logic
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            therm_sync_q <= `FDL_SYNC_RST;
        end else begin
            therm_sync_q <= fdl_sync_step(therm_sync_q, thermal_shutdown_i);
        end
    end

    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            overcur_sync_q <= `FDL_SYNC_RST;
        end else begin
            overcur_sync_q <= fdl_sync_step(overcur_sync_q,
                overcurrent_shutdown_i);
        end
    end

    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            warn_sync_q <= `FDL_SYNC_RST;
        end else begin
            warn_sync_q <= fdl_sync_step(warn_sync_q, thermal_warning_i);
        end
    end

    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            low_power_standby_sync_q <= `FDL_SYNC_RST;
        end else begin
            low_power_standby_sync_q <= fdl_sync_step(low_power_standby_sync_q, low_power_standby_i);
        end
    end

    wire therm_s;
    wire overcur_s;
    wire warn_s;
    wire low_power_standby_s;

    assign therm_s = therm_sync_q[1];
    assign overcur_s = overcur_sync_q[1];
    assign warn_s = warn_sync_q[1];
    assign low_power_standby_s = low_power_standby_sync_q[1];

    // ------------------------------------------------------------------
    // masking filters
    // ------------------------------------------------------------------
    wire therm_hit;
    wire overcur_hit;
    wire warn_hit;

    fdl_mask_filter #(
        .MASK_LEN(`FDL_THERM_MASK_CLK)
    ) u_therm_mask (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .ind_i(therm_s),
        .hit_o(therm_hit)
    );

    fdl_mask_filter #(
        .MASK_LEN(`FDL_OVERCUR_MASK_CLK)
    ) u_overcur_mask (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .ind_i(overcur_s),
        .hit_o(overcur_hit)
    );

    fdl_mask_filter #(
        .MASK_LEN(`FDL_WARN_MASK_CLK)
    ) u_warn_mask (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .ind_i(warn_s),
        .hit_o(warn_hit)
    );

    // ------------------------------------------------------------------
    // fault latches
    // ------------------------------------------------------------------
    reg therm_latch_q;
    reg therm_latch_d;
    reg overcur_latch_q;
    reg overcur_latch_d;

    // standby clears, a fresh confirmation relatches
    always @* begin
        therm_latch_d = fdl_latch_next(therm_latch_q,
            therm_hit, low_power_standby_s);
        overcur_latch_d = fdl_latch_next(overcur_latch_q,
            overcur_hit, low_power_standby_s);
    end

    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            therm_latch_q <= `FDL_LATCH_RST;
            overcur_latch_q <= `FDL_LATCH_RST;
        end else begin
            therm_latch_q <= therm_latch_d;
            overcur_latch_q <= overcur_latch_d;
        end
    end

    // ------------------------------------------------------------------
    // output stage shutdown
    // ------------------------------------------------------------------
    wire any_fault_d;

    // outputs load the next latch state, so they move with the latch
    assign any_fault_d = therm_latch_d || overcur_latch_d;

    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            outputs_off_o <= 1'b1;
            thermal_fault_o <= 1'b0;
            overcurrent_fault_o <= 1'b0;
        end else begin
            // internal reset of the output stage
            outputs_off_o <= any_fault_d || low_power_standby_s;
            thermal_fault_o <= therm_latch_d;
            overcurrent_fault_o <= overcur_latch_d;
        end
    end

    // ------------------------------------------------------------------
    // open-drain fault flag
    // ------------------------------------------------------------------
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fault_flag_o <= 1'b0;
            fault_flag_oe_o <= 1'b0;
        end else begin
            // drive low only while latched
            fault_flag_o <= 1'b0;
            fault_flag_oe_o <= any_fault_d;
        end
    end

    // ------------------------------------------------------------------
    // open-drain thermal warning, self-recovering
    // ------------------------------------------------------------------
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            thermal_warning_out_o <= 1'b0;
            thermal_warning_out_oe_o <= 1'b0;
        end else begin
            // follows the filtered condition, no latch
            thermal_warning_out_o <= 1'b0;
            thermal_warning_out_oe_o <= warn_hit;
        end
    end

endmodule // fdl_fault_detect_latch

`default_nettype wire

//--- rtl/fdl_consts.vh
`ifndef FDL_CONSTS_VH
`define FDL_CONSTS_VH

// ----------------------------------------------------------------------
// masking counts, in cycles of the internal fast oscillator
// ----------------------------------------------------------------------
`define FDL_MASK_CNT_W 6
`define FDL_THERM_MASK_CLK 6'h20
`define FDL_OVERCUR_MASK_CLK 6'h08
`define FDL_WARN_MASK_CLK 6'h10

// ----------------------------------------------------------------------
// nominal masking times, in ns, at the nominal oscillator rate
// ----------------------------------------------------------------------
`define FDL_THERM_MASK_TIME_NS 5000
`define FDL_OVERCUR_MASK_TIME_NS 1250
`define FDL_WARN_MASK_TIME_NS 2500

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define FDL_MASK_CNT_RST 6'h00
`define FDL_LATCH_RST 1'b0
`define FDL_SYNC_RST 2'h0

`endif

//--- rtl/fdl_mask_filter.v
`timescale 1ns/1ns
`default_nettype none
`include "fdl_consts.vh"

// counts consecutive cycles with the indication present
module fdl_mask_filter #(
    parameter [`FDL_MASK_CNT_W-1:0] MASK_LEN = `FDL_THERM_MASK_CLK
) (
    input wire core_clk_i,
    input wire rstn_i,
    input wire ind_i,
    output wire hit_o
);

    reg [`FDL_MASK_CNT_W-1:0] cnt_q;
    reg [`FDL_MASK_CNT_W-1:0] cnt_d;

    // ------------------------------------------------------------------
    // saturating run-length counter
    // ------------------------------------------------------------------
    always @* begin
        cnt_d = cnt_q;
        if (!ind_i) begin
            cnt_d = `FDL_MASK_CNT_RST;
        end else if (cnt_q != MASK_LEN) begin
            cnt_d = cnt_q + {{(`FDL_MASK_CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_q <= `FDL_MASK_CNT_RST;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // confirmed only after the full run
    assign hit_o = ind_i && (cnt_q == MASK_LEN);

endmodule // fdl_mask_filter

`default_nettype wire

//--- testbench/fdl_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module fdl_host_model (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic fault_flag_i,
    input wire logic fault_flag_oe_i,
    input wire logic resume_i,
    output logic err_pin_o,
    output logic low_power_standby_o
);
    logic [2:0] st_q;
    // pull-up on the released flag pin
    assign err_pin_o = fault_flag_oe_i ? fault_flag_i : 1'b1;
    assign low_power_standby_o = st_q != 3'h0;
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_q <= 3'h0;
        end else if (st_q != 3'h0) begin
            st_q <= st_q - 3'h1;
        end else if (resume_i && !err_pin_o) begin
            st_q <= 3'h4;
        end
    end
endmodule // fdl_host_model
`default_nettype wire

//--- testbench/fdl_fault_detect_latch_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module fdl_checker (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic thermal_shutdown_i,
    input wire logic overcurrent_shutdown_i,
    input wire logic thermal_warning_i,
    input wire logic low_power_standby_i,
    input wire logic outputs_off_o,
    input wire logic thermal_fault_o,
    input wire logic overcurrent_fault_o,
    input wire logic fault_flag_o,
    input wire logic fault_flag_oe_o,
    input wire logic thermal_warning_out_o,
    input wire logic thermal_warning_out_oe_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    logic [5:0] th_q, oc_q, wn_q;
    // consecutive sampled cycles of each indication
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            th_q <= 6'h00;
            oc_q <= 6'h00;
            wn_q <= 6'h00;
        end else begin
            th_q <= thermal_shutdown_i ? th_q + {5'h00, ~&th_q} : 6'h00;
            oc_q <= overcurrent_shutdown_i ? oc_q + {5'h00, ~&oc_q} : 6'h00;
            wn_q <= thermal_warning_i ? wn_q + {5'h00, ~&wn_q} : 6'h00;
        end
    end
    a_th_mask: assert property (
        $rose(thermal_fault_o) |-> $past(th_q, 2) > 6'h20)
        else $error("thermal early");
    a_th_set: assert property (
        th_q == 6'h21 |-> ##2 thermal_fault_o)
        else $error("thermal missed");
    a_oc_mask: assert property (
        $rose(overcurrent_fault_o) |-> $past(oc_q, 2) > 6'h08)
        else $error("overcurrent early");
    a_oc_set: assert property (
        oc_q == 6'h09 |-> ##2 overcurrent_fault_o)
        else $error("overcurrent missed");
    a_off_on_fault: assert property (
        thermal_fault_o || overcurrent_fault_o |-> outputs_off_o)
        else $error("outputs not off");
    a_flag_pin: assert property (
        fault_flag_oe_o == (thermal_fault_o || overcurrent_fault_o)
        && !fault_flag_o)
        else $error("flag pin wrong");
    a_latch_clear: assert property (
        $fell(thermal_fault_o) || $fell(overcurrent_fault_o)
        |-> $past(low_power_standby_i, 3))
        else $error("latch lost");
    a_warn_mask: assert property (
        $rose(thermal_warning_out_oe_o)
        |-> $past(wn_q, 2) > 6'h10 && !thermal_warning_out_o)
        else $error("warning early");
    a_warn_free: assert property (
        !thermal_warning_i |-> ##3 !thermal_warning_out_oe_o)
        else $error("warning stuck");
endmodule // fdl_checker
bind fdl_fault_detect_latch fdl_checker i_fdl_checker (.*);
`default_nettype wire

//--- testbench/fdl_fault_detect_latch_tb.sv
`timescale 1ns/1ns
`default_nettype none
module fdl_fault_detect_latch_tb;
    logic core_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [2:0] ind = 3'h0;
    logic resume = 1'b0;
    logic sb, err, off, th, oc, fl, fl_oe, wo, wo_oe, sb1, sb2;
    logic e_th, e_oc, e_wn, e_off;
    logic [31:0] seed = 32'he081;
    int run[3], h1[3], len[3] = '{32, 8, 16};
    int n_fail = 0, num_checks = 0, j, k;
    wire logic [7:0] got_v = {off, th, oc, fl, fl_oe, wo, wo_oe, err};
    wire logic [7:0] exp_v = {e_off, e_th, e_oc, 1'b0, e_th | e_oc, 1'b0,
        e_wn, ~(e_th | e_oc)};
    fdl_fault_detect_latch i_fdl_fault_detect_latch (.core_clk_i(core_clk_i),
        .rstn_i(rstn_i), .thermal_shutdown_i(ind[0]),
        .overcurrent_shutdown_i(ind[1]), .thermal_warning_i(ind[2]),
        .low_power_standby_i(sb), .outputs_off_o(off), .thermal_fault_o(th),
        .overcurrent_fault_o(oc), .fault_flag_o(fl), .fault_flag_oe_o(fl_oe),
        .thermal_warning_out_o(wo), .thermal_warning_out_oe_o(wo_oe));
    fdl_host_model i_fdl_host_model (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
        .fault_flag_i(fl), .fault_flag_oe_i(fl_oe), .resume_i(resume),
        .err_pin_o(err), .low_power_standby_o(sb));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic report_and_stop();
        if (n_fail == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic hold(input logic [2:0] v, input int n);
        @(posedge core_clk_i) ind <= v;
        repeat (n) @(posedge core_clk_i);
        ind <= 3'h0;
    endtask
    task automatic clear();
        int t;
        repeat (4) @(posedge core_clk_i);
        resume <= 1'b1;
        for (t = 0; t < 100 && err !== 1'b1; t++) @(negedge core_clk_i);
        if (t == 100) begin
            n_fail++;
            report_and_stop();
        end
        @(posedge core_clk_i) resume <= 1'b0;
    endtask
    // reference: two-cycle sync, consecutive-run masks, latches
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            run = '{0, 0, 0};
            h1 = '{0, 0, 0};
            {e_th, e_oc, e_wn, e_off, sb1, sb2} = 6'h04;
        end else begin
            e_th = h1[0] > len[0] || (e_th && !sb2);
            e_oc = h1[1] > len[1] || (e_oc && !sb2);
            e_wn = h1[2] > len[2];
            e_off = e_th || e_oc || sb2;
            h1 = run;
            for (j = 0; j < 3; j++) run[j] = ind[j] ? run[j] + 1 : 0;
            sb2 = sb1;
            sb1 = sb;
        end
    end
    always @(negedge core_clk_i) begin
        chk(got_v, exp_v);
    end
    initial begin
        forever #50 core_clk_i = ~core_clk_i;
    end
    initial begin
        repeat (3) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        for (k = 0; k < 400; k++) begin
            seed = xs(seed);
            @(posedge core_clk_i) ind <= seed[2:0] & seed[5:3];
        end
        @(posedge core_clk_i) ind <= 3'h0;
        for (k = 0; k < 6; k++) begin
            hold(3'h1 << (k / 2), len[k / 2] + k % 2);
            clear();
        end
        @(posedge core_clk_i) resume <= 1'b1;
        hold(3'h3, 40);
        clear();
        hold(3'h7, 40);
        @(posedge core_clk_i) rstn_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        repeat (5) @(posedge core_clk_i);
        report_and_stop();
    end
endmodule // fdl_fault_detect_latch_tb
`default_nettype wire
